//--- rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------
// Command word field positions
// ----------------------------------------------------------------
`define RTC_TA_MSB 15
`define RTC_TA_LSB 11
`define RTC_TR_BIT 10
`define RTC_SA_MSB 9
`define RTC_SA_LSB 5
`define RTC_WC_MSB 4
`define RTC_WC_LSB 0

// ----------------------------------------------------------------
// Address and code values
// ----------------------------------------------------------------
`define RTC_BCAST_ADDR 5'h1F
`define RTC_MODE_SA_LO 5'h00
`define RTC_MODE_SA_HI 5'h1F
`define RTC_MC_DATA_MIN 5'h10
`define RTC_MC_NODATA_MAX 5'h0F
`define RTC_MC_RSV_TX_MIN 5'h09
`define RTC_MC_RSV_MIN 5'h16
`define RTC_MC_16 5'h10
`define RTC_MC_17 5'h11
`define RTC_MC_18 5'h12
`define RTC_MC_19 5'h13
`define RTC_MC_20 5'h14
`define RTC_MC_21 5'h15
`define RTC_WC_ZERO 5'h00
`define RTC_WC_MAX 6'h20
`define RTC_ONE_WORD 6'h01
`define RTC_NO_WORDS 6'h00

// ----------------------------------------------------------------
// Illegalization table
// ----------------------------------------------------------------
`define RTC_TBL_DEPTH 256
`define RTC_TBL_AW 8
`define RTC_TBL_DW 16
`define RTC_TBL_RESET 16'h0000
`define RTC_DATA_RESET 16'h0000

`endif

//--- rtc_pkg.sv
package rtc_pkg;

    // Received word as handed over by the decoder
    typedef struct packed {
        logic strobe;
        logic cmd_sync;
        logic sync_ok;
        logic manch_ok;
        logic count_ok;
        logic [15:0] data;
        logic parity;
    } rtc_rx_word_t;

    typedef enum logic [1:0] {
        RTC_RESP_NONE,
        RTC_RESP_CLEAR,
        RTC_RESP_MSG_ERR
    } rtc_resp_t;

    // Classification of one received word
    typedef struct packed {
        logic done;
        logic word_valid;
        logic is_command;
        logic [15:0] data;
        logic [4:0] term_addr;
        logic direction_tx;
        logic [4:0] subaddr;
        logic [4:0] count_code;
        logic accepted;
        logic broadcast;
        logic mode_cmd;
        logic undefined;
        logic reserved;
        logic illegal;
        logic status_update;
        rtc_resp_t response;
        logic [5:0] rx_words;
        logic [5:0] tx_words;
    } rtc_result_t;

endpackage : rtc_pkg

//--- rtc_classifier.sv
`timescale 1ns/10ps
`include "rtc_regs.svh"
// Summary of operation
// RULE1: Command word is sync, address, direction, subaddress, count fields, then parity.
// RULE2: Command or data type comes only from the sync pattern type.
// RULE3: Valid word needs good sync, Manchester, bit count and odd parity.
// RULE4: Valid command word keeps only its sixteen data bits.
// RULE5: Command is ours when its address equals the latched terminal address.
// RULE6: Address 31 is the broadcast address.
// RULE7: Broadcast disable makes address 31 invalid; invalid commands get no response.
// RULE8: Subaddress 1 to 30 is a subaddress command; direction bit sets data flow.
// RULE9: Word count field gives 1 to 32 words; zero means 32.
// RULE10: Subaddress 0 or 31 is a mode command; low bits are mode code.
// RULE11: Mode codes 16 to 31 carry one word, received or sent after status.
// RULE12: Mode codes 0 to 15 with direction 0 are undefined.
// RULE13: Exactly 22 mode commands are classed undefined.
// RULE14: Undefined-mode-invalid set makes undefined commands invalid, no status update.
// RULE15: Undefined-mode-invalid resets to 0 elsewhere; undefined then follow the table.
// RULE16: Legal undefined commands get clear status; 17, 20, 21 transmit add a word.
// RULE17: Illegal mode command gets message error status only, no mode data word.
// RULE18: The 27 reserved mode commands follow their table entries.
// RULE19: Host leaves all entries 0, or sets the 22 undefined entries to 1.
// RULE20: After master reset every table entry reads 0.
// RULE21: Illegal command suppresses transmitted data, sends status with message error.
// RULE22: Table of 256 sixteen-bit words decides legality.
// RULE23: Table index is broadcast, direction, subaddress and count or mode code.
module rtc_classifier (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Received word from the decoder
    input rtc_pkg::rtc_rx_word_t rx_word_i,
    // Configuration
    input wire logic [4:0] terminal_address_i,
    input wire logic broadcast_disable_i,
    input wire logic undefined_mode_invalid_i,
    // Illegalization table host port and classification result
    input wire logic tbl_wr_en_i,
    input wire logic tbl_rd_en_i,
    input wire logic [`RTC_TBL_AW-1:0] tbl_addr_i,
    input wire logic [`RTC_TBL_DW-1:0] tbl_wr_data_i,
    output rtc_pkg::rtc_result_t result_o,
    output logic [`RTC_TBL_DW-1:0] tbl_rd_data_o
);

    // ----------------------------------------------------------------
    // Mode code decoding
    // ----------------------------------------------------------------
    function automatic logic rtc_is_undefined(input logic [4:0] mc, input logic tx);
        logic r;
        r = 1'b0;
        if (!tx && (mc <= `RTC_MC_NODATA_MAX)) begin // [RULE12]
            r = 1'b1;
        end
        if (!tx && (mc == `RTC_MC_16 || mc == `RTC_MC_18 || mc == `RTC_MC_19)) begin // [RULE13]
            r = 1'b1;
        end
        if (tx && (mc == `RTC_MC_17 || mc == `RTC_MC_20 || mc == `RTC_MC_21)) begin // [RULE13]
            r = 1'b1;
        end
        return r;
    endfunction : rtc_is_undefined

    function automatic logic rtc_is_reserved(input logic [4:0] mc, input logic tx);
        logic r;
        r = 1'b0;
        if (tx && (mc >= `RTC_MC_RSV_TX_MIN) && (mc <= `RTC_MC_NODATA_MAX)) begin // [RULE18]
            r = 1'b1;
        end
        if (mc >= `RTC_MC_RSV_MIN) begin // [RULE18]
            r = 1'b1;
        end
        return r;
    endfunction : rtc_is_reserved

    // ----------------------------------------------------------------
    // Illegalization table
    // ----------------------------------------------------------------
    logic [`RTC_TBL_DW-1:0] tbl_mem [`RTC_TBL_DEPTH];
    logic [`RTC_TBL_DW-1:0] tbl_rd_data_d;
    logic [`RTC_TBL_DW-1:0] tbl_rd_data_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `RTC_TBL_DEPTH; i++) begin
                tbl_mem[i] <= `RTC_TBL_RESET; // [RULE20]
            end
        end else if (tbl_wr_en_i) begin
            tbl_mem[tbl_addr_i] <= tbl_wr_data_i; // [RULE22]
        end
    end

    always_comb begin
        tbl_rd_data_d = tbl_rd_data_q;
        if (tbl_rd_en_i) begin
            tbl_rd_data_d = tbl_mem[tbl_addr_i];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tbl_rd_data_q <= `RTC_TBL_RESET;
        end else begin
            tbl_rd_data_q <= tbl_rd_data_d;
        end
    end

    assign tbl_rd_data_o = tbl_rd_data_q;

    // ----------------------------------------------------------------
    // Word classification
    // ----------------------------------------------------------------
    rtc_pkg::rtc_result_t res_d;
    rtc_pkg::rtc_result_t res_q;
    logic [4:0] f_ta;
    logic f_tx;
    logic [4:0] f_sa;
    logic [4:0] f_wc;
    logic [5:0] f_count;
    logic [`RTC_TBL_AW-1:0] ill_word;
    logic [`RTC_TBL_DW-1:0] ill_row;

    always_comb begin
        f_ta = rx_word_i.data[`RTC_TA_MSB:`RTC_TA_LSB]; // [RULE1]
        f_tx = rx_word_i.data[`RTC_TR_BIT]; // [RULE1]
        f_sa = rx_word_i.data[`RTC_SA_MSB:`RTC_SA_LSB]; // [RULE1]
        f_wc = rx_word_i.data[`RTC_WC_MSB:`RTC_WC_LSB]; // [RULE1]
        f_count = (f_wc == `RTC_WC_ZERO) ? `RTC_WC_MAX : {1'b0, f_wc}; // [RULE9]

        res_d = '0;
        res_d.response = rtc_pkg::RTC_RESP_NONE;
        res_d.done = rx_word_i.strobe;
        res_d.is_command = rx_word_i.cmd_sync; // [RULE2]
        res_d.word_valid = rx_word_i.sync_ok && rx_word_i.manch_ok && rx_word_i.count_ok
            && (^{rx_word_i.data, rx_word_i.parity}); // [RULE3]
        if (res_d.word_valid) begin
            res_d.data = rx_word_i.data; // [RULE4]
        end
        res_d.term_addr = f_ta;
        res_d.direction_tx = f_tx;
        res_d.subaddr = f_sa;
        res_d.count_code = f_wc;

        res_d.broadcast = (f_ta == `RTC_BCAST_ADDR) && !broadcast_disable_i; // [RULE6] [RULE7]
        res_d.mode_cmd = (f_sa == `RTC_MODE_SA_LO) || (f_sa == `RTC_MODE_SA_HI); // [RULE10]
        res_d.undefined = res_d.mode_cmd && rtc_is_undefined(f_wc, f_tx);
        res_d.reserved = res_d.mode_cmd && rtc_is_reserved(f_wc, f_tx);

        // Row holds 16 codes; the top count bit is the low bit of the row index
        ill_word = {res_d.broadcast, f_tx, f_sa, f_wc[4]}; // [RULE23]
        ill_row = tbl_mem[ill_word]; // [RULE22]
        res_d.illegal = ill_row[f_wc[3:0]]; // [RULE18]

        res_d.accepted = rx_word_i.strobe && res_d.word_valid && rx_word_i.cmd_sync
            && ((f_ta == terminal_address_i && f_ta != `RTC_BCAST_ADDR) || res_d.broadcast) // [RULE5] [RULE7]
            && !(res_d.undefined && undefined_mode_invalid_i); // [RULE14] [RULE15]

        if (res_d.accepted) begin
            res_d.status_update = 1'b1;
            if (!res_d.mode_cmd) begin
                if (f_tx) begin
                    res_d.tx_words = f_count; // [RULE8]
                end else begin
                    res_d.rx_words = f_count; // [RULE8]
                end
            end else if (f_wc >= `RTC_MC_DATA_MIN) begin
                if (f_tx) begin
                    res_d.tx_words = `RTC_ONE_WORD; // [RULE11] [RULE16]
                end else begin
                    res_d.rx_words = `RTC_ONE_WORD; // [RULE11]
                end
            end
            if (res_d.illegal) begin
                res_d.response = rtc_pkg::RTC_RESP_MSG_ERR; // [RULE17] [RULE21]
                res_d.tx_words = `RTC_NO_WORDS; // [RULE17] [RULE21]
            end else begin
                res_d.response = rtc_pkg::RTC_RESP_CLEAR; // [RULE16]
            end
        end else if (!res_d.is_command || !res_d.word_valid || !rx_word_i.strobe) begin
            res_d.broadcast = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign result_o = res_q;

endmodule : rtc_classifier

//--- rtc_bc_model.sv
`timescale 1ns/10ps
module rtc_bc_model (
    // Clock
    input wire logic core_clk_i,
    // Word to the classifier
    output rtc_pkg::rtc_rx_word_t rx_word_o
);
    initial rx_word_o = '0;
    // Odd parity unless a bad word is asked for
    task send(input logic cmd, input logic [15:0] d, input logic bad);
        @(negedge core_clk_i);
        rx_word_o = '{1'b1, cmd, 1'b1, 1'b1, 1'b1, d, ~^d ^ bad};
        @(negedge core_clk_i);
        rx_word_o.strobe = 1'b0;
        rx_word_o.data = ~d;
    endtask : send
endmodule : rtc_bc_model

//--- rtc_classifier_asserts.sv
`timescale 1ns/10ps
module rtc_classifier_asserts (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Inputs
    input rtc_pkg::rtc_rx_word_t rx_word_i,
    input wire logic [4:0] terminal_address_i,
    input wire logic broadcast_disable_i,
    input wire logic undefined_mode_invalid_i,
    input wire logic tbl_wr_en_i,
    input wire logic tbl_rd_en_i,
    input wire logic [7:0] tbl_addr_i,
    input wire logic [15:0] tbl_wr_data_i,
    // Outputs
    input rtc_pkg::rtc_result_t result_o,
    input wire logic [15:0] tbl_rd_data_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_good_word;
        rx_word_i.strobe && rx_word_i.sync_ok && rx_word_i.manch_ok && rx_word_i.count_ok
            && ^{rx_word_i.data, rx_word_i.parity};
    endsequence
    sequence s_answer;
        ##1 result_o.done;
    endsequence
    a_answer_next: assert property (
        rx_word_i.strobe |-> s_answer) else $error("No result after a word");
    a_sync_type: assert property (
        rx_word_i.strobe |=> result_o.is_command == $past(rx_word_i.cmd_sync)) else $error("Word type wrong");
    a_bad_parity: assert property (
        rx_word_i.strobe && !(^{rx_word_i.data, rx_word_i.parity}) |=> !result_o.word_valid)
        else $error("Bad parity accepted");
    a_data_kept: assert property (
        s_good_word |=> result_o.word_valid && result_o.data == $past(rx_word_i.data)) else $error("Data lost");
    a_bcast_off: assert property (
        rx_word_i.strobe && rx_word_i.data[15:11] == 5'h1F && broadcast_disable_i
            |=> !result_o.accepted && result_o.response == rtc_pkg::RTC_RESP_NONE) else $error("Broadcast taken");
    a_count_zero: assert property (
        result_o.done && result_o.accepted && !result_o.mode_cmd && !result_o.direction_tx
            && result_o.count_code == 5'h00 |-> result_o.rx_words == 6'h20) else $error("Count zero wrong");
    a_illegal_err: assert property (
        result_o.done && result_o.accepted && result_o.illegal
            |-> result_o.response == rtc_pkg::RTC_RESP_MSG_ERR && result_o.tx_words == 6'h00)
        else $error("Illegal reply wrong");
    a_umc_off: assert property (
        result_o.done && result_o.undefined && $past(undefined_mode_invalid_i) |-> !result_o.accepted)
        else $error("Undefined taken");
endmodule : rtc_classifier_asserts
bind rtc_classifier rtc_classifier_asserts u_rtc_classifier_asserts (.core_clk_i, .rst_n_i, .rx_word_i,
    .terminal_address_i, .broadcast_disable_i, .undefined_mode_invalid_i, .tbl_wr_en_i, .tbl_rd_en_i,
    .tbl_addr_i, .tbl_wr_data_i, .result_o, .tbl_rd_data_o);

//--- rtc_classifier_tb_top.sv
`timescale 1ns/10ps
module rtc_classifier_tb_top;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] ta = 5'h05;
    logic bd = 1'b0;
    logic umi = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rd;
    rtc_pkg::rtc_rx_word_t rx;
    rtc_pkg::rtc_result_t r;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    always #50 core_clk_i = ~core_clk_i;
    rtc_bc_model u_rtc_bc_model (.core_clk_i(core_clk_i), .rx_word_o(rx));
    rtc_classifier u_rtc_classifier (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_word_i(rx),
        .terminal_address_i(ta), .broadcast_disable_i(bd), .undefined_mode_invalid_i(umi), .tbl_wr_en_i(we),
        .tbl_rd_en_i(re), .tbl_addr_i(ad), .tbl_wr_data_i(wd), .result_o(r), .tbl_rd_data_o(rd));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    task cmd(input logic [4:0] a, input logic tr, input logic [4:0] sa, input logic [4:0] wc, input logic cs,
        input logic bad);
        u_rtc_bc_model.send(cs, {a, tr, sa, wc}, bad);
    endtask : cmd
    task tbl(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk_i);
        we = w;
        re = !w;
        ad = a;
        wd = d;
        @(negedge core_clk_i);
        we = 1'b0;
        re = 1'b0;
    endtask : tbl
    task t_word;
        cmd(ta, 1'b1, 5'h01, 5'h03, 1'b1, 1'b0);
        check("data", r.data, {ta, 1'b1, 5'h01, 5'h03});
        check("accepted", r.accepted, 1'b1);
        check("tx_words", r.tx_words, 16'h0003);
        check("fields", {r.term_addr, r.direction_tx, r.subaddr, r.count_code}, {5'h05, 1'b1, 5'h01, 5'h03});
        check("status", {r.status_update, r.response}, {1'b1, rtc_pkg::RTC_RESP_CLEAR});
        cmd(ta, 1'b1, 5'h01, 5'h03, 1'b1, 1'b1);
        check("bad valid", r.word_valid, 1'b0);
        cmd(ta, 1'b1, 5'h01, 5'h03, 1'b0, 1'b0);
        check("is_command", r.is_command, 1'b0);
        $display("word test done");
    endtask : t_word
    task t_addr;
        cmd(ta + 5'h01, 1'b0, 5'h02, 5'h00, 1'b1, 1'b0);
        check("other", r.accepted, 1'b0);
        cmd(5'h1F, 1'b0, 5'h02, 5'h00, 1'b1, 1'b0);
        check("bcast", {r.broadcast, r.accepted}, 2'h3);
        check("rx_words", r.rx_words, 16'h0020);
        bd = 1'b1;
        cmd(5'h1F, 1'b0, 5'h02, 5'h00, 1'b1, 1'b0);
        check("bcast off", {r.accepted, r.response}, 3'h0);
        bd = 1'b0;
        $display("address test done");
    endtask : t_addr
    task t_mode;
        int nu;
        int nr;
        logic tr;
        logic [4:0] mc;
        nu = 0;
        nr = 0;
        for (int i = 0; i < 64; i++) begin
            {tr, mc} = i[5:0];
            cmd(ta, tr, i[1] ? 5'h1F : 5'h00, mc, 1'b1, 1'b0);
            nu += r.undefined;
            nr += r.reserved;
            check("mode", r.mode_cmd, 1'b1);
            check("words", {r.tx_words, r.rx_words}, {5'h00, mc[4] & tr, 5'h00, mc[4] & !tr});
            check("undef", r.undefined, tr ? (mc == 17 || mc == 20 || mc == 21) : (mc <= 16 || mc == 18 || mc == 19));
            check("rsv", r.reserved, mc >= 22 || (tr && mc >= 9 && mc <= 15));
        end
        check("n undef", nu[15:0], 16'h0016);
        check("n rsv", nr[15:0], 16'h001B);
        $display("mode test done");
    endtask : t_mode
    task t_table;
        tbl(1'b0, 8'h41, 16'h0000);
        check("reset entry", rd, 16'h0000);
        tbl(1'b1, 8'h41, 16'h0002);
        cmd(ta, 1'b1, 5'h00, 5'h11, 1'b1, 1'b0);
        check("illegal", {r.illegal, r.response, r.tx_words}, {1'b1, rtc_pkg::RTC_RESP_MSG_ERR, 6'h00});
        cmd(ta, 1'b1, 5'h00, 5'h14, 1'b1, 1'b0);
        check("in form", {r.response, r.tx_words}, {rtc_pkg::RTC_RESP_CLEAR, 6'h01});
        umi = 1'b1;
        cmd(ta, 1'b1, 5'h00, 5'h14, 1'b1, 1'b0);
        check("umc off", {r.accepted, r.status_update}, 2'h0);
        umi = 1'b0;
        tbl(1'b0, 8'h41, 16'h0000);
        check("entry", rd, 16'h0002);
        $display("table test done");
    endtask : t_table
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        t_word();
        t_addr();
        t_mode();
        t_table();
        give_verdict();
    end
endmodule : rtc_classifier_tb_top
